/* File: pkg/pia_pkg.sv */
// Package: register map, field layout and reset values of the indirect access slice
package pia_pkg;
   localparam logic [4:0] OFF_EXT_ACCESS_CONTROL = 5'h0d;
   localparam logic [4:0] OFF_EXT_ADDRESS_DATA = 5'h0e;
   localparam logic [4:0] OFF_GIGABIT_CAP_FLAGS = 5'h0f;
   localparam logic [4:0] OFF_PHY_GENERAL_CONTROL = 5'h10;
   localparam logic [4:0] OFF_PHY_GENERAL_STATE = 5'h11;

   localparam logic [15:0] RST_EXT_ACCESS_CONTROL = 16'h0000;
   localparam logic [15:0] RST_EXT_ADDRESS_DATA = 16'h0000;
   localparam logic [15:0] RST_GIGABIT_CAP_FLAGS = 16'hf000;
   localparam logic [15:0] RST_PHY_GENERAL_CONTROL = 16'h5048;

   // Writable bits of the two mixed registers; reserved bits read zero
   localparam logic [15:0] MASK_EXT_ACCESS_CONTROL = 16'hc01f;
   localparam logic [15:0] MASK_PHY_GENERAL_CONTROL = 16'hf77b;

   localparam logic [4:0] EXTENDED_DEVICE_SEL = 5'h1f;
   localparam int DEV_SEL_MSB = 4;
   localparam int FUNC_MSB = 15;
   localparam int FUNC_LSB = 14;
   localparam int TX_FIFO_MSB = 15;
   localparam int TX_FIFO_LSB = 14;
   localparam int RX_FIFO_MSB = 13;
   localparam int RX_FIFO_LSB = 12;
   localparam int FORCE_LINK_BIT = 10;
   localparam int POWER_SAVE_MSB = 9;
   localparam int POWER_SAVE_LSB = 8;
   localparam int PAIR_SWAP_MSB = 6;
   localparam int PAIR_SWAP_LSB = 5;
   localparam int REF_CLK_DIS_BIT = 4;
   localparam int TEST_CLK_ROUTE_BIT = 3;
   localparam int DRIVER_INV_BIT = 1;
   localparam int JABBER_DIS_BIT = 0;
   localparam int SPEED_MSB = 15;
   localparam int SPEED_LSB = 14;
   localparam int LINK_BIT = 10;
   localparam logic [1:0] SPEED_1G = 2'h2;

   // Extended register space depth (address bits)
   localparam int EXT_AW = 6;

   typedef enum logic [1:0]
   {
      PIA_FN_ADDRESS = 2'h0,
      PIA_FN_DATA = 2'h1,
      PIA_FN_DATA_INC_RW = 2'h2,
      PIA_FN_DATA_INC_WR = 2'h3
   } pia_func_t;

   typedef enum logic [1:0]
   {
      PIA_PS_NORMAL = 2'h0,
      PIA_PS_RESERVED = 2'h1,
      PIA_PS_ACTIVE_SLEEP = 2'h2,
      PIA_PS_PASSIVE_SLEEP = 2'h3
   } pia_power_t;

   typedef enum logic [1:0]
   {
      PIA_IDLE = 2'b00,
      PIA_READ_WAIT = 2'b01,
      PIA_READ_DONE = 2'b11
   } pia_state_t;

   typedef struct packed
   {
      logic req;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } pia_mgmt_req_t;

   typedef struct packed
   {
      logic ack;
      logic [15:0] rdata;
   } pia_mgmt_rsp_t;

   typedef struct packed
   {
      logic [2:0] tx_fifo_depth;
      logic tx_fifo_active;
      logic [2:0] rx_fifo_depth;
      logic rx_fifo_active;
      logic link_good;
      pia_power_t power_save;
      logic mdi_force_straight;
      logic mdi_force_crossed;
      logic mdi_auto;
      logic ref_clock_output_en;
      logic test_clock_route;
      logic driver_output_invert;
      logic jabber_enable;
   } pia_phy_ctrl_t;

   // Depth in bytes or nibbles for a two-bit FIFO code, shared by both FIFOs
   function automatic logic [3:0] fifo_depth(input logic [1:0] code);
      case (code)
         2'h0: fifo_depth = 4'h3;
         2'h1: fifo_depth = 4'h4;
         2'h2: fifo_depth = 4'h6;
         default: fifo_depth = 4'h8;
      endcase
   endfunction : fifo_depth
endpackage : pia_pkg

/* File: logic/pia_ext_mem.sv */
// Extended register storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module pia_ext_mem
   import pia_pkg::*;
(
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [EXT_AW-1:0] waddr_i,
   input wire logic [15:0] wdata_i,
   input wire logic [EXT_AW-1:0] raddr_i,
   output logic [15:0] rdata_o
);
   logic [15:0] mem_q [0:(1<<EXT_AW)-1];
   logic [15:0] rdata_q;

   // No reset: contents are undefined until written, like a plain RAM
   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem_q[waddr_i] <= wdata_i;
      end
      rdata_q <= mem_q[raddr_i];
   end

   assign rdata_o = rdata_q;
endmodule : pia_ext_mem
`default_nettype wire

/* File: logic/pia_regs.sv */
// Register slice: indirect extended access pair, capability word and Phy_general_control word
//
// What this block does
// R1 - Five-bit device select: data-function accesses reach the extended RAM only with select 0x1F; address-function writes ignore it.
// R2 - Controller writes 0x1F into select bits before using the address/data word.
// R3 - Function field: address, data, data increment on read/write, increment on write.
// R4 - Function 00 reaches the address register; other functions reach the data register with select 0x1F, otherwise reads return the address register.
// R5 - Indirect reads and writes go only through the control and address/data pair.
// R6 - Post-increment advances the stored extended address after each qualifying access.
// R7 - Capability word reports four gigabit duplex flags set; other bits read zero.
// R8 - Transmit FIFO depth codes select 3, 4, 6, 8; active only 1000BaseT GMII.
// R9 - Receive FIFO depth same encoding, reset code 1; active only with SGMII.
// R10 - Forced link bit reports link good at 1G regardless of qualification.
// R11 - Power save: 0 normal, 2 active sleep, 3 passive sleep; 1 reserved.
// R12 - Crossover: 0 straight, 1 crossed, upper codes automatic; reset 2 or strap.
// R13 - Reference clock disable bit stops the 125 MHz output; its reset value 0 runs it after release, while ref_clock_output_en is held low during reset.
// R14 - Test clock route: clear to receive clock pin, set to reference pin.
// R15 - Driver inversion bit inverts transmission, except while mirror operation is active.
// R16 - Jabber disable bit turns off jabber protection; its reset value 0 turns protection on after release, while jabber_enable is held low during reset.
`timescale 1ns/1ps
`default_nettype none
module pia_regs
   import pia_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire pia_mgmt_req_t mgmt_req_i,
   output pia_mgmt_rsp_t mgmt_rsp_o,
   input wire logic [1:0] pair_swap_strap_i,
   input wire logic [1:0] speed_i,
   input wire logic link_qualified_i,
   input wire logic [15:0] phy_general_state_i,
   input wire logic gmii_mode_i,
   input wire logic sgmii_mode_i,
   input wire logic mirror_mode_i,
   output pia_phy_ctrl_t phy_ctrl_o,
   output logic link_good_o
);
   logic [15:0] access_ctrl_q, access_ctrl_d;
   logic [15:0] ext_addr_q, ext_addr_d;
   logic [15:0] phy_ctrl_q, phy_ctrl_d;
   pia_state_t state_q, state_d;
   pia_mgmt_rsp_t rsp_q, rsp_d;
   pia_phy_ctrl_t out_q, out_d;
   logic link_good_q, link_good_d;
   logic [1:0] strap_s1_q, strap_s2_q;
   logic [1:0] speed_s1_q, speed_s2_q;
   logic [3:0] misc_s1_q, misc_s2_q;
   logic [15:0] state_s1_q, state_s2_q;
   logic strap_taken_q, strap_taken_d;
   logic mem_we;
   logic [EXT_AW-1:0] mem_addr;
   logic [15:0] mem_rdata;
   pia_func_t func;
   logic ext_sel;
   logic data_hit;
   logic rd_hit;
   logic req_taken;
   logic wr_taken;
   logic link_qual_s;
   logic gmii_s;
   logic sgmii_s;
   logic mirror_s;
   logic at_1g;
   logic [1:0] swap_code;
   logic [15:0] reg_rdata;

   // Address step shared by the write and the read increment paths
   function automatic logic [15:0] step_addr(input logic [15:0] a);
      step_addr = a + 16'h0001;
   endfunction : step_addr

   // Post-increment decode; reads step only in the read-and-write mode
   function automatic logic post_inc(input pia_func_t fn, input logic is_write);
      post_inc = (fn == PIA_FN_DATA_INC_RW) || (is_write && fn == PIA_FN_DATA_INC_WR);
   endfunction : post_inc

   // Pins come from other domains: two flops before any use
   always_ff @(posedge clk_i)
   begin
      strap_s1_q <= pair_swap_strap_i;
      strap_s2_q <= strap_s1_q;
      speed_s1_q <= speed_i;
      speed_s2_q <= speed_s1_q;
      misc_s1_q <= {link_qualified_i, gmii_mode_i, sgmii_mode_i, mirror_mode_i};
      misc_s2_q <= misc_s1_q;
      state_s1_q <= phy_general_state_i;
      state_s2_q <= state_s1_q;
   end

   // Named taps of the synchronised mode pins
   assign link_qual_s = misc_s2_q[3];
   assign gmii_s = misc_s2_q[2];
   assign sgmii_s = misc_s2_q[1];
   assign mirror_s = misc_s2_q[0];
   assign at_1g = (speed_s2_q == SPEED_1G);

   // A select other than the extended code leaves data accesses inert
   assign func = pia_func_t'(access_ctrl_q[FUNC_MSB:FUNC_LSB]);
   assign ext_sel = (access_ctrl_q[DEV_SEL_MSB:0] == EXTENDED_DEVICE_SEL); // [R1] [R2]
   assign req_taken = mgmt_req_i.req && (state_q == PIA_IDLE);
   assign wr_taken = req_taken && mgmt_req_i.wr;
   // Gated by the idle state so a refused request cannot touch the RAM
   assign data_hit = req_taken && (mgmt_req_i.addr == OFF_EXT_ADDRESS_DATA)
                     && (func != PIA_FN_ADDRESS) && ext_sel; // [R4] [R5]
   assign rd_hit = data_hit && !mgmt_req_i.wr;
   assign mem_we = data_hit && mgmt_req_i.wr;
   assign mem_addr = ext_addr_q[EXT_AW-1:0];
   assign swap_code = phy_ctrl_q[PAIR_SWAP_MSB:PAIR_SWAP_LSB];

   // A data write lands at the current address before the address steps
   pia_ext_mem u_mem
   (
      .clk_i(clk_i),
      .we_i(mem_we),
      .waddr_i(mem_addr),
      .wdata_i(mgmt_req_i.wdata),
      .raddr_i(mem_addr),
      .rdata_o(mem_rdata)
   );

   // Register writes and indirect access
   always_comb
   begin
      access_ctrl_d = access_ctrl_q;
      ext_addr_d = ext_addr_q;
      phy_ctrl_d = phy_ctrl_q;
      strap_taken_d = 1'b1;
      // Crossover default is caught from the strap once, after reset releases
      if (!strap_taken_q)
      begin
         phy_ctrl_d[PAIR_SWAP_MSB:PAIR_SWAP_LSB] = strap_s2_q; // [R12]
      end
      if (wr_taken)
      begin
         case (mgmt_req_i.addr)
            OFF_EXT_ACCESS_CONTROL:
            begin
               access_ctrl_d = mgmt_req_i.wdata & MASK_EXT_ACCESS_CONTROL; // [R3]
            end
            OFF_EXT_ADDRESS_DATA:
            begin
               if (func == PIA_FN_ADDRESS)
               begin
                  ext_addr_d = mgmt_req_i.wdata; // [R4]
               end
               else if (post_inc(func, 1'b1) && ext_sel)
               begin
                  ext_addr_d = step_addr(ext_addr_q); // [R6]
               end
            end
            OFF_PHY_GENERAL_CONTROL:
            begin
               phy_ctrl_d = mgmt_req_i.wdata & MASK_PHY_GENERAL_CONTROL;
            end
            // Writes to read-only words and unmapped offsets are acked and dropped
            default:
            begin
               access_ctrl_d = access_ctrl_q;
            end
         endcase
      end
      // Read increment only after the data has been captured
      if (state_q == PIA_READ_DONE && post_inc(func, 1'b0))
      begin
         ext_addr_d = step_addr(ext_addr_q); // [R6] [R3]
      end
   end

   // Strap is taken on the first edge after release; a write in that edge wins
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         access_ctrl_q <= RST_EXT_ACCESS_CONTROL;
         ext_addr_q <= RST_EXT_ADDRESS_DATA;
         phy_ctrl_q <= RST_PHY_GENERAL_CONTROL;
         strap_taken_q <= 1'b0;
      end
      else
      begin
         access_ctrl_q <= access_ctrl_d;
         ext_addr_q <= ext_addr_d;
         phy_ctrl_q <= phy_ctrl_d;
         strap_taken_q <= strap_taken_d;
      end
   end

   // Plain register read data, one decode for every directly mapped word
   always_comb
   begin
      reg_rdata = 16'h0000;
      case (mgmt_req_i.addr)
         OFF_EXT_ACCESS_CONTROL: reg_rdata = access_ctrl_q;
         OFF_EXT_ADDRESS_DATA: reg_rdata = ext_addr_q; // [R4]
         OFF_GIGABIT_CAP_FLAGS: reg_rdata = RST_GIGABIT_CAP_FLAGS; // [R7]
         OFF_PHY_GENERAL_CONTROL: reg_rdata = phy_ctrl_q;
         OFF_PHY_GENERAL_STATE: reg_rdata = state_s2_q;
         default: reg_rdata = 16'h0000;
      endcase
   end

   // Read path; memory reads take two extra cycles, through the wait and done states, for the registered RAM output
   always_comb
   begin
      state_d = state_q;
      rsp_d = '0;
      case (state_q)
         PIA_IDLE:
         begin
            if (rd_hit)
            begin
               state_d = PIA_READ_WAIT;
            end
            else if (req_taken)
            begin
               rsp_d.ack = 1'b1;
               if (!mgmt_req_i.wr)
               begin
                  rsp_d.rdata = reg_rdata;
               end
            end
         end
         PIA_READ_WAIT:
         begin
            // Requests in the two pending cycles are dropped without an ack
            state_d = PIA_READ_DONE;
         end
         PIA_READ_DONE:
         begin
            rsp_d.ack = 1'b1;
            rsp_d.rdata = mem_rdata; // [R5]
            state_d = PIA_IDLE;
         end
         default:
         begin
            state_d = PIA_IDLE;
         end
      endcase
   end

   // Registered response: ack stands exactly one cycle
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state_q <= PIA_IDLE;
         rsp_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         rsp_q <= rsp_d;
      end
   end

   // Decoded control outputs, registered so downstream sees clean levels
   always_comb
   begin
      // Depth 8 does not fit three bits and shows as 0; read the code field instead
      out_d.tx_fifo_depth = 3'(fifo_depth(phy_ctrl_q[TX_FIFO_MSB:TX_FIFO_LSB])); // [R8]
      out_d.tx_fifo_active = gmii_s && at_1g; // [R8]
      out_d.rx_fifo_depth = 3'(fifo_depth(phy_ctrl_q[RX_FIFO_MSB:RX_FIFO_LSB])); // [R9]
      out_d.rx_fifo_active = sgmii_s; // [R9]
      out_d.link_good = link_good_q;
      out_d.power_save = pia_power_t'(phy_ctrl_q[POWER_SAVE_MSB:POWER_SAVE_LSB]); // [R11]
      // Reserved power code is treated as normal operation
      if (out_d.power_save == PIA_PS_RESERVED)
      begin
         out_d.power_save = PIA_PS_NORMAL; // [R11]
      end
      out_d.mdi_force_straight = (swap_code == 2'h0); // [R12]
      out_d.mdi_force_crossed = (swap_code == 2'h1); // [R12]
      out_d.mdi_auto = swap_code[1]; // [R12]
      out_d.ref_clock_output_en = !phy_ctrl_q[REF_CLK_DIS_BIT]; // [R13]
      out_d.test_clock_route = phy_ctrl_q[TEST_CLK_ROUTE_BIT]; // [R14]
      // Inversion is held off while mirroring, whatever the control bit says
      out_d.driver_output_invert = phy_ctrl_q[DRIVER_INV_BIT] && !mirror_s; // [R15]
      out_d.jabber_enable = !phy_ctrl_q[JABBER_DIS_BIT]; // [R16]
      // Forced link applies only at 1G; other speeds keep normal qualification
      link_good_d = link_qual_s
                    || (phy_ctrl_q[FORCE_LINK_BIT] && at_1g); // [R10]
   end

   always_ff @(posedge clk_i)
   begin
      // Outputs sit at zero in reset and settle a few cycles after release
      if (sys_rst_i)
      begin
         out_q <= '0;
         link_good_q <= 1'b0;
      end
      else
      begin
         out_q <= out_d;
         link_good_q <= link_good_d;
      end
   end

   assign mgmt_rsp_o = rsp_q;
   assign phy_ctrl_o = out_q;
   assign link_good_o = link_good_q;
endmodule : pia_regs
`default_nettype wire

/* File: verif/pia_regs_properties.sv */
// Checker: port-level properties of the register slice
`timescale 1ns/1ps
`default_nettype none
module pia_regs_chk
   import pia_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire pia_mgmt_req_t mgmt_req_i,
   input wire pia_mgmt_rsp_t mgmt_rsp_o,
   input wire logic [1:0] speed_i,
   input wire logic link_qualified_i,
   input wire logic gmii_mode_i,
   input wire logic sgmii_mode_i,
   input wire logic mirror_mode_i,
   input wire pia_phy_ctrl_t phy_ctrl_o,
   input wire logic link_good_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   wire logic rd = mgmt_req_i.req && !mgmt_req_i.wr;
   // Extended data read: two quiet cycles, then the answer
   sequence s_slow_ack;
      !mgmt_rsp_o.ack ##2 mgmt_rsp_o.ack;
   endsequence
   a_plain_ack: assert property (mgmt_req_i.req && (mgmt_req_i.wr ||
      mgmt_req_i.addr != OFF_EXT_ADDRESS_DATA) |=> mgmt_rsp_o.ack) else $error("ack missing");
   a_ext_read_lat: assert property (rd && mgmt_req_i.addr == OFF_EXT_ADDRESS_DATA
      |=> mgmt_rsp_o.ack or s_slow_ack) else $error("extended read latency");
   a_cap_word: assert property (rd && mgmt_req_i.addr == OFF_GIGABIT_CAP_FLAGS
      |=> mgmt_rsp_o.rdata == 16'hf000) else $error("capability word wrong");
   a_ctrl_reserved_zero: assert property (rd && mgmt_req_i.addr == OFF_PHY_GENERAL_CONTROL
      |=> (mgmt_rsp_o.rdata & 16'h0884) == 16'h0) else $error("reserved bits set");
   a_link_follow: assert property (link_qualified_i [*6] |-> link_good_o)
      else $error("qualified link not reported");
   a_link_drop: assert property ((!link_qualified_i && speed_i != SPEED_1G) [*6]
      |-> !link_good_o) else $error("link reported without cause");
   a_tx_fifo_gate: assert property ((!gmii_mode_i) [*6] |-> !phy_ctrl_o.tx_fifo_active)
      else $error("tx fifo active without gmii");
   a_rx_fifo_follow: assert property ($stable(sgmii_mode_i) [*6]
      |-> phy_ctrl_o.rx_fifo_active == sgmii_mode_i) else $error("rx fifo active wrong");
   a_mirror_gate: assert property (mirror_mode_i [*6]
      |-> !phy_ctrl_o.driver_output_invert) else $error("inversion in mirror mode");
endmodule : pia_regs_chk
bind pia_regs pia_regs_chk pia_regs_chk_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .mgmt_req_i(mgmt_req_i), .mgmt_rsp_o(mgmt_rsp_o), .speed_i(speed_i),
   .link_qualified_i(link_qualified_i), .gmii_mode_i(gmii_mode_i),
   .sgmii_mode_i(sgmii_mode_i), .mirror_mode_i(mirror_mode_i), .phy_ctrl_o(phy_ctrl_o),
   .link_good_o(link_good_o));
`default_nettype wire

/* File: verif/pia_mgmt_model.sv */
// Partner: management controller issuing register requests
`timescale 1ns/1ps
`default_nettype none
module pia_mgmt_model
   import pia_pkg::*;
(
   input wire logic clk_i,
   output var pia_mgmt_req_t req_o,
   input wire pia_mgmt_rsp_t rsp_i
);
   initial req_o = '0;
   // One-cycle pulse: a request still high at the ack edge would be taken twice
   task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
      output logic [15:0] q);
      int n;
      @(negedge clk_i);
      req_o = '{1'b1, w, a, d};
      @(negedge clk_i);
      req_o = '{1'b0, ~w, ~a, ~d};
      n = 0;
      while (rsp_i.ack !== 1'b1 && n < 8)
      begin
         @(negedge clk_i);
         n++;
      end
      q = (n < 8) ? rsp_i.rdata : 16'hxxxx;
   endtask : xfer
   task automatic ext_setup(input logic [1:0] fn, input logic [15:0] a);
      logic [15:0] q;
      xfer(1'b1, OFF_EXT_ACCESS_CONTROL, {2'h0, 9'h0, EXTENDED_DEVICE_SEL}, q);
      xfer(1'b1, OFF_EXT_ADDRESS_DATA, a, q);
      xfer(1'b1, OFF_EXT_ACCESS_CONTROL, {fn, 9'h0, EXTENDED_DEVICE_SEL}, q);
   endtask : ext_setup
endmodule : pia_mgmt_model
`default_nettype wire

/* File: verif/phy_indirect_access_and_control_tb.sv */
// Testbench: register slice driven through the management model
`timescale 1ns/1ps
`default_nettype none
module phy_indirect_access_and_control_tb
   import pia_pkg::*;
;
   typedef struct packed {logic w; logic [4:0] a; logic [15:0] d; logic [15:0] e;} pia_row_t;
   localparam pia_row_t ROWS [11] = '{'{1'h0, 5'h0d, 16'h0, 16'h0}, '{1'h0, 5'h0e, 16'h0, 16'h0},
      '{1'h0, 5'h0f, 16'h0, 16'hf000}, '{1'h1, 5'h0f, 16'hffff, 16'h0},
      '{1'h0, 5'h0f, 16'h0, 16'hf000}, '{1'h0, 5'h10, 16'h0, 16'h5048},
      '{1'h0, 5'h11, 16'h0, 16'ha5c3}, '{1'h1, 5'h0d, 16'hffff, 16'h0},
      '{1'h0, 5'h0d, 16'h0, 16'hc01f}, '{1'h1, 5'h03, 16'hffff, 16'h0},
      '{1'h0, 5'h03, 16'h0, 16'h0}};
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [1:0] strap = 2'h2;
   logic [1:0] speed = 2'h0;
   logic qual = 1'b0, gmii = 1'b0, sgmii = 1'b0, mirror = 1'b0;
   pia_mgmt_req_t req;
   pia_mgmt_rsp_t rsp;
   pia_phy_ctrl_t ctl;
   logic link;
   logic [15:0] q, v;
   int errors = 0;
   int cmp_count = 0;
   initial forever #2.5 clk_i = ~clk_i;
   pia_regs pia_regs_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mgmt_req_i(req),
      .mgmt_rsp_o(rsp), .pair_swap_strap_i(strap), .speed_i(speed), .link_qualified_i(qual),
      .phy_general_state_i(16'ha5c3), .gmii_mode_i(gmii), .sgmii_mode_i(sgmii),
      .mirror_mode_i(mirror), .phy_ctrl_o(ctl), .link_good_o(link));
   pia_mgmt_model pia_mgmt_model_inst (.clk_i(clk_i), .req_o(req), .rsp_i(rsp));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      pia_mgmt_model_inst.xfer(1'b0, a, 16'h0, q);
      chk(32'(q), 32'(e));
   endtask : rd
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      pia_mgmt_model_inst.xfer(1'b1, a, d, q);
      chk(32'(q), 32'h0);
   endtask : wr
   function automatic pia_phy_ctrl_t model(input logic [15:0] c);
      logic [3:0] dep [4];
      pia_phy_ctrl_t m;
      dep = '{4'h3, 4'h4, 4'h6, 4'h8};
      m.tx_fifo_depth = dep[c[15:14]][2:0];
      m.tx_fifo_active = gmii && speed == SPEED_1G;
      m.rx_fifo_depth = dep[c[13:12]][2:0];
      m.rx_fifo_active = sgmii;
      m.link_good = qual || (c[10] && speed == SPEED_1G);
      m.power_save = pia_power_t'(c[9:8] == 2'h1 ? 2'h0 : c[9:8]);
      m.mdi_force_straight = c[6:5] == 2'h0;
      m.mdi_force_crossed = c[6:5] == 2'h1;
      m.mdi_auto = c[6];
      m.ref_clock_output_en = !c[4];
      m.test_clock_route = c[3];
      m.driver_output_invert = c[1] && !mirror;
      m.jabber_enable = !c[0];
      return m;
   endfunction : model
   task automatic summarize;
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   initial
   begin
      #50us;
      errors++;
      summarize();
   end
   initial
   begin
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      sys_rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      chk(32'(ctl), 32'(model(16'h5048)));
      foreach (ROWS[i])
      begin
         if (ROWS[i].w)
            wr(ROWS[i].a, ROWS[i].d);
         else
            rd(ROWS[i].a, ROWS[i].e);
      end
      // Every field code, with the gating inputs swept alongside
      for (int i = 0; i < 16; i++)
      begin
         v = {i[1:0], ~i[1:0], 1'b0, i[0], i[1:0], 1'b0, i[3:2], i[2], i[3], 1'b0, i[1], i[0]};
         speed = i[0] ? SPEED_1G : 2'h1;
         gmii = i[3];
         sgmii = i[1];
         mirror = i[2];
         qual = i == 14;
         wr(OFF_PHY_GENERAL_CONTROL, v);
         repeat (8) @(negedge clk_i);
         chk(32'(ctl), 32'(model(v)));
         chk(32'(link), 32'(qual || (v[10] && speed == SPEED_1G)));
         rd(OFF_PHY_GENERAL_CONTROL, v & 16'hf77b);
      end
      pia_mgmt_model_inst.ext_setup(2'h2, 16'h8);
      wr(OFF_EXT_ADDRESS_DATA, 16'haaaa);
      wr(OFF_EXT_ADDRESS_DATA, 16'hbbbb);
      pia_mgmt_model_inst.ext_setup(2'h3, 16'h8);
      wr(OFF_EXT_ADDRESS_DATA, 16'hcccc);
      rd(OFF_EXT_ADDRESS_DATA, 16'hbbbb);
      rd(OFF_EXT_ADDRESS_DATA, 16'hbbbb);
      pia_mgmt_model_inst.ext_setup(2'h2, 16'h8);
      rd(OFF_EXT_ADDRESS_DATA, 16'hcccc);
      rd(OFF_EXT_ADDRESS_DATA, 16'hbbbb);
      pia_mgmt_model_inst.ext_setup(2'h1, 16'h8);
      rd(OFF_EXT_ADDRESS_DATA, 16'hcccc);
      rd(OFF_EXT_ADDRESS_DATA, 16'hcccc);
      wr(OFF_EXT_ACCESS_CONTROL, 16'h001f);
      rd(OFF_EXT_ADDRESS_DATA, 16'h0008);
      wr(OFF_EXT_ACCESS_CONTROL, 16'h4003);
      wr(OFF_EXT_ADDRESS_DATA, 16'hdddd);
      rd(OFF_EXT_ADDRESS_DATA, 16'h0008);
      pia_mgmt_model_inst.ext_setup(2'h1, 16'h8);
      rd(OFF_EXT_ADDRESS_DATA, 16'hcccc);
      // Second reset with another strap value
      strap = 2'h1;
      sys_rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      sys_rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rd(OFF_PHY_GENERAL_CONTROL, 16'h5028);
      rd(OFF_EXT_ACCESS_CONTROL, 16'h0);
      repeat (4) @(negedge clk_i);
      chk(32'(ctl), 32'(model(16'h5028)));
      summarize();
   end
endmodule : phy_indirect_access_and_control_tb
`default_nettype wire
